// [pkg/msc_pkg.sv]
/*
  Shared constants for the system control block.
  Assumes one instruction cycle per clk_sys edge.
*/
package msc_pkg;
  // ==========================================
  // Program counter and stack
  localparam logic [10:0] MSC_PC_RESET = 11'h000; // Start address
  localparam logic [10:0] MSC_INT_VECTOR = 11'h0ff; // Interrupt entry
  localparam logic [10:0] MSC_PC_ONE = 11'h001; // Increment step
  // ==========================================
  // Enable register bit positions
  localparam int MSC_EN_SER_MODE = 0; // Counter when set
  localparam int MSC_EN_INT = 1; // Interrupt enable
  localparam int MSC_EN_LDRV = 2; // Parallel port drive
  localparam int MSC_EN_SO = 3; // Serial out enable
  localparam logic [3:0] MSC_EN_RESET = 4'h0;
  localparam logic MSC_SKL_RESET = 1'b1;
  // ==========================================
  // Core write selects
  localparam logic [2:0] MSC_SEL_NONE = 3'h0;
  localparam logic [2:0] MSC_SEL_ACC = 3'h1;
  localparam logic [2:0] MSC_SEL_RAMADR = 3'h2;
  localparam logic [2:0] MSC_SEL_CARRY = 3'h3;
  localparam logic [2:0] MSC_SEL_DOUT = 3'h4;
  localparam logic [2:0] MSC_SEL_GPORT = 3'h5;
  localparam logic [2:0] MSC_SEL_EN = 3'h6;
  localparam logic [2:0] MSC_SEL_Q = 3'h7;
  // ==========================================
  // Oscillator-out pin options
  localparam logic [1:0] MSC_CKO_CRYSTAL = 2'h0;
  localparam logic [1:0] MSC_CKO_HALT_PORT = 2'h1;
  localparam logic [1:0] MSC_CKO_GP_INPUT = 2'h2;
  // ==========================================
  // Pin indices in the sampled group
  localparam int MSC_PIN_INT = 0;
  localparam int MSC_PIN_CS = 1;
  localparam int MSC_PIN_WR = 2;
  localparam int MSC_PIN_RD = 3;
  localparam int MSC_PIN_SI = 4;
  localparam int MSC_PIN_CKO = 5;
  localparam int MSC_PIN_RST = 6;
  localparam int MSC_PIN_IN0 = 7;
  localparam int MSC_NPINS = 8;
  // ==========================================
  // Reset timing count (in instruction cycles), pin-read bit, FIFO size
  localparam logic [1:0] MSC_RESET_MIN_CYC = 2'h3; // Reset low span
  localparam int MSC_ACC_CKO_BIT = 2; // Accumulator bit for pin read
  localparam int MSC_FIFO_W = 8;
  localparam int MSC_FIFO_D = 4;
  // Run state, one-hot
  typedef enum logic [1:0] {
    MSC_RUN = 2'b01,
    MSC_HALT = 2'b10
  } msc_run_t;
endpackage

// [design/msc_top.sv]
/*
  System control of a small 4-bit controller core, plus host write FIFO.
  Assumes the sequencer runs on clk_sys and pulses instr_done per instruction.
*/
// Contract
// - Shift mode: shift from input, gated output
// - Counter mode: output equals enable bit
// - Ack pushes PC+1, vectors, clears enable
// - Ack needs enable, qualified fall, done
// - Ack deferred during transfer or load runs
// - Skip saved on ack, restored on return
// - Read strobe low drives latch to port
// - Strobes act only with select low
// - Write strobe latches port into latch; code queues it in the FIFO, latch loads on host_data_take
// - Port bit 0 is ready, write clears
// - Init after reset low three cycles
// - Init clears registers, sets sync latch
// - Time base: two-bit prescale feeds timer
// - Timer load and reset clear prescaler
// - Event mode counts qualified select falls
// - Halt by instruction or pin, freezes
// - Pin low continues, reset restarts
// - Alternate external clock ignores halt
// - Crystal halt drives pin, reset wakes
// - Halt port pin reflects halt status
// - General input pin read into bit 2
// - Shift left per cycle, count down falls
`timescale 1ns/1ps

// ==========================================
// Small FIFO for host write data
module msc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage words
  logic [AW-1:0] wptr; // Write index
  logic [AW-1:0] rptr; // Read index
  logic [AW:0] count; // Fill level
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data = mem[rptr];
  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  // Pointers and level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(D-1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(D-1)) ? '0 : rptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // msc_fifo

// ==========================================
// System control top
module msc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mask options
  input wire logic opt_host_bus,
  input wire logic opt_timer_event,
  input wire logic [1:0] opt_cko_mode,
  input wire logic opt_dual_ext,
  // Pins
  input wire logic reset_pin_n,
  input wire logic interrupt_read_strobe_pin,
  input wire logic chip_select_event_pin,
  input wire logic write_strobe_pin,
  input wire logic in0_pin,
  input wire logic serial_in_pin,
  input wire logic osc_out_halt_pin_in,
  output logic osc_out_halt_pin_out,
  output logic osc_out_halt_pin_oe,
  input wire logic int_pin,
  input wire logic [7:0] lport_in,
  output logic [7:0] lport_out,
  output logic lport_oe,
  output logic serial_out,
  output logic sync_clock_out,
  output logic ready_handshake_out,
  // Sequencer
  input wire logic instr_done,
  input wire logic instr_is_transfer,
  input wire logic instr_is_lbi,
  input wire logic instr_jump,
  input wire logic instr_call,
  input wire logic [10:0] jump_addr,
  input wire logic return_instr,
  input wire logic halt_instr,
  input wire logic load_timer_instr,
  input wire logic [7:0] load_timer_data,
  input wire logic exchange_acc_serial_instr,
  input wire logic read_input_latches_instr,
  input wire logic timer_ovf_clear,
  input wire logic skip_pending,
  input wire logic [2:0] core_wr_sel,
  input wire logic [7:0] core_wr_data,
  input wire logic host_ready_set,
  input wire logic host_data_take,
  input wire logic alt_clock_sel,
  // Status
  output logic [10:0] pc,
  output logic int_ack,
  output logic skip_restore,
  output logic [3:0] acc,
  output logic [6:0] ram_addr,
  output logic carry,
  output logic [3:0] dout,
  output logic [3:0] gport,
  output logic [3:0] en,
  output logic [7:0] qlatch,
  output logic [3:0] serial_shift_counter,
  output logic [7:0] timer,
  output logic timer_ovf,
  output logic halted,
  output logic init_active,
  output logic host_fifo_full
);
  import msc_pkg::*;

  // Qualified falling edge: oldest high, two newer lows
  function automatic logic qfall(input logic [2:0] h);
    return h == 3'b100;
  endfunction

  // ==========================================
  // Pin sampling
  logic [MSC_NPINS-1:0] pin_raw; // Raw pins
  logic [MSC_NPINS-1:0] sync1; // First stage, read by sync2 only
  logic [MSC_NPINS-1:0] sync2; // Second stage
  logic [2:0] hist [MSC_NPINS]; // Sample history, bit0 newest
  logic [7:0] l_s1; // Port data first stage
  logic [7:0] l_s2; // Port data second stage
  assign pin_raw = {in0_pin, reset_pin_n, osc_out_halt_pin_in, serial_in_pin,
                    interrupt_read_strobe_pin, write_strobe_pin,
                    chip_select_event_pin, int_pin};
  // Two-stage synchronisers and history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '1;
      sync2 <= '1;
      l_s1 <= 8'h00;
      l_s2 <= 8'h00;
      for (int i = 0; i < MSC_NPINS; i++) begin
        hist[i] <= 3'h7;
      end
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      l_s1 <= lport_in;
      l_s2 <= l_s1;
      for (int i = 0; i < MSC_NPINS; i++) begin
        hist[i] <= {hist[i][1:0], sync2[i]};
      end
    end
  end

  // Decoded pin events
  logic int_fall; // Qualified interrupt fall
  logic cs_fall; // Qualified select fall
  logic si_fall; // Qualified serial input fall
  logic in0_fall; // Input 0 fall
  logic wr_fall; // Input 3 fall
  logic host_sel; // Host select level
  logic host_wr; // Host write pulse
  logic host_rd; // Host read level
  logic cko_lvl; // Sampled osc-out pin
  assign int_fall = qfall(hist[MSC_PIN_INT]);
  assign cs_fall = qfall(hist[MSC_PIN_CS]);
  assign si_fall = qfall(hist[MSC_PIN_SI]);
  assign in0_fall = hist[MSC_PIN_IN0][1:0] == 2'b10;
  assign wr_fall = hist[MSC_PIN_WR][1:0] == 2'b10;
  assign host_sel = opt_host_bus && !hist[MSC_PIN_CS][0];
  assign host_wr = host_sel && wr_fall;
  assign host_rd = host_sel && !hist[MSC_PIN_RD][0];
  assign cko_lvl = hist[MSC_PIN_CKO][0];

  // ==========================================
  // Reset pin qualification
  logic [1:0] rst_low_cnt; // Consecutive low cycles
  // Count low samples; init holds once three are seen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_low_cnt <= 2'h0;
      init_active <= 1'b1;
    end else begin
      if (hist[MSC_PIN_RST][0]) begin
        rst_low_cnt <= 2'h0;
        init_active <= 1'b0;
      end else if (rst_low_cnt != MSC_RESET_MIN_CYC) begin
        rst_low_cnt <= rst_low_cnt + 2'h1;
        init_active <= (rst_low_cnt + 2'h1) == MSC_RESET_MIN_CYC;
      end
    end
  end

  // ==========================================
  // Halt control
  msc_run_t run_state; // Run or halt
  logic halt_block; // Alternate external clock in use
  logic halt_req; // Halt request this cycle
  logic halt_port; // Pin is halt port
  assign halt_block = opt_dual_ext && alt_clock_sel;
  assign halt_port = opt_cko_mode == MSC_CKO_HALT_PORT;
  assign halt_req = !halt_block && (halt_instr || (halt_port && cko_lvl));
  // Enter and leave halt; reset restarts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_state <= MSC_RUN;
    end else if (init_active) begin
      run_state <= MSC_RUN;
    end else begin
      case (run_state)
        MSC_RUN: begin
          if (halt_req) begin
            run_state <= MSC_HALT;
          end
        end
        MSC_HALT: begin
          if (halt_port && !cko_lvl) begin
            run_state <= MSC_RUN;
          end
        end
        default: begin
          run_state <= MSC_RUN;
        end
      endcase
    end
  end
  assign halted = run_state == MSC_HALT;

  // Osc-out pin drive: halt flag in halt-port and crystal modes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_out_halt_pin_out <= 1'b0;
      osc_out_halt_pin_oe <= 1'b0;
    end else begin
      osc_out_halt_pin_out <= halted;
      osc_out_halt_pin_oe <= opt_cko_mode != MSC_CKO_GP_INPUT;
    end
  end

  // Core, PC, serial, timer and output-latch state advance only while running
  logic go;
  assign go = !halted && !init_active;

  // ==========================================
  // Interrupt, PC and stack
  logic int_pend; // Latched qualified interrupt fall
  logic ack; // Acknowledge this cycle
  logic [10:0] stk [3]; // Return stack, 0 on top
  logic stk_skip [3]; // Saved skip per level
  assign ack = go && instr_done && en[MSC_EN_INT] && int_pend
               && !instr_is_transfer && !instr_is_lbi;
  // Pending interrupt flag; a new fall wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_pend <= 1'b0;
    end else if (init_active) begin
      int_pend <= 1'b0;
    end else if (int_fall) begin
      int_pend <= 1'b1;
    end else if (ack) begin
      int_pend <= 1'b0;
    end
  end
  // PC update, push on call or ack, pop on return
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc <= MSC_PC_RESET;
      int_ack <= 1'b0;
      skip_restore <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        stk[i] <= 11'h000;
        stk_skip[i] <= 1'b0;
      end
    end else if (init_active) begin
      pc <= MSC_PC_RESET;
      int_ack <= 1'b0;
      skip_restore <= 1'b0;
    end else begin
      int_ack <= ack;
      skip_restore <= 1'b0;
      if (go && instr_done) begin
        if (ack || instr_call) begin
          stk[0] <= pc + MSC_PC_ONE;
          stk[1] <= stk[0];
          stk[2] <= stk[1];
          stk_skip[0] <= ack && skip_pending;
          stk_skip[1] <= stk_skip[0];
          stk_skip[2] <= stk_skip[1];
          pc <= ack ? MSC_INT_VECTOR : jump_addr;
        end else if (return_instr) begin
          pc <= stk[0];
          skip_restore <= stk_skip[0];
          stk[0] <= stk[1];
          stk[1] <= stk[2];
          stk_skip[0] <= stk_skip[1];
          stk_skip[1] <= stk_skip[2];
        end else if (instr_jump) begin
          pc <= jump_addr;
        end else begin
          pc <= pc + MSC_PC_ONE;
        end
      end
    end
  end

  // ==========================================
  // Core registers
  logic [1:0] in_latch; // Input fall latches
  // Register writes, exchange, input read; ack clears enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 4'h0;
      ram_addr <= 7'h00;
      carry <= 1'b0;
      dout <= 4'h0;
      gport <= 4'h0;
      en <= MSC_EN_RESET;
      in_latch <= 2'h0;
    end else if (init_active) begin
      acc <= 4'h0;
      ram_addr <= 7'h00;
      carry <= 1'b0;
      dout <= 4'h0;
      gport <= 4'h0;
      en <= MSC_EN_RESET;
      in_latch <= 2'h0;
    end else if (go) begin
      case (core_wr_sel)
        MSC_SEL_ACC: acc <= core_wr_data[3:0];
        MSC_SEL_RAMADR: ram_addr <= core_wr_data[6:0];
        MSC_SEL_CARRY: carry <= core_wr_data[0];
        MSC_SEL_DOUT: dout <= core_wr_data[3:0];
        MSC_SEL_GPORT: gport <= core_wr_data[3:0];
        MSC_SEL_EN: en <= core_wr_data[3:0];
        default: begin
        end
      endcase
      if (exchange_acc_serial_instr) begin
        acc <= serial_shift_counter;
      end
      if (read_input_latches_instr) begin
        acc <= {in_latch[1], 1'b0, 1'b0, in_latch[0]};
        if (opt_cko_mode == MSC_CKO_GP_INPUT) begin
          acc[MSC_ACC_CKO_BIT] <= cko_lvl;
        end
      end
      if (ack) begin
        en[MSC_EN_INT] <= 1'b0;
      end
      // Fall on an input wins over the read-clear
      in_latch <= (read_input_latches_instr ? 2'h0 : in_latch)
                  | {wr_fall, in0_fall};
    end
  end

  // ==========================================
  // Serial register and sync clock
  logic sync_clock_latch; // Sync clock latch
  logic sk_phase; // Sync clock toggle
  logic [3:0] next_sio;
  always_comb begin
    next_sio = serial_shift_counter;
    if (!en[MSC_EN_SER_MODE]) begin
      next_sio = {serial_shift_counter[2:0], hist[MSC_PIN_SI][0]};
    end else if (si_fall) begin
      next_sio = serial_shift_counter - 4'h1;
    end
    if (exchange_acc_serial_instr) begin
      next_sio = acc;
    end
  end
  // Serial register, latch and pin outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_shift_counter <= 4'h0;
      sync_clock_latch <= MSC_SKL_RESET;
      sk_phase <= 1'b0;
      serial_out <= 1'b0;
      sync_clock_out <= 1'b0;
    end else if (init_active) begin
      sync_clock_latch <= MSC_SKL_RESET;
      sk_phase <= 1'b0;
      serial_out <= 1'b0;
      sync_clock_out <= 1'b0;
    end else if (go) begin
      serial_shift_counter <= next_sio;
      if (exchange_acc_serial_instr) begin
        sync_clock_latch <= carry;
      end
      sk_phase <= !sk_phase;
      if (en[MSC_EN_SER_MODE]) begin
        serial_out <= en[MSC_EN_SO];
        sync_clock_out <= sync_clock_latch;
      end else begin
        serial_out <= en[MSC_EN_SO] && next_sio[3];
        sync_clock_out <= sync_clock_latch && sk_phase;
      end
    end
  end

  // ==========================================
  // Timer
  logic [1:0] prescale; // Time-base prescaler
  logic tick; // Timer increment
  assign tick = opt_timer_event ? cs_fall : (prescale == 2'h3);
  // Timer, prescaler and overflow flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 2'h0;
      timer <= 8'h00;
      timer_ovf <= 1'b0;
    end else if (init_active) begin
      prescale <= 2'h0;
      timer <= 8'h00;
      timer_ovf <= 1'b0;
    end else if (go) begin
      prescale <= load_timer_instr ? 2'h0 : prescale + 2'h1;
      if (load_timer_instr) begin
        timer <= load_timer_data;
      end else if (tick) begin
        timer <= timer + 8'h01;
      end
      // Overflow set wins over the clear
      if (tick && !load_timer_instr && timer == 8'hff) begin
        timer_ovf <= 1'b1;
      end else if (timer_ovf_clear) begin
        timer_ovf <= 1'b0;
      end
    end
  end

  // ==========================================
  // Host parallel bus
  logic fifo_in_ready; // Space for host write
  logic fifo_out_valid; // Word waiting
  logic [7:0] fifo_out_data; // Head word
  logic fifo_pop; // Drain into latch
  assign fifo_pop = go && host_data_take;
  msc_fifo #(.W(MSC_FIFO_W), .D(MSC_FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(host_wr),
    .in_data(l_s2),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );
  // Output latch, ready flag and port drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qlatch <= 8'h00;
      ready_handshake_out <= 1'b0;
      lport_out <= 8'h00;
      lport_oe <= 1'b0;
      host_fifo_full <= 1'b0;
    end else begin
      host_fifo_full <= !fifo_in_ready;
      lport_out <= qlatch;
      lport_oe <= host_rd || en[MSC_EN_LDRV];
      if (init_active) begin
        ready_handshake_out <= 1'b0;
      end else if (go) begin
        if (fifo_out_valid && fifo_pop) begin
          qlatch <= fifo_out_data;
        end else if (core_wr_sel == MSC_SEL_Q) begin
          qlatch <= core_wr_data;
        end
        if (opt_host_bus) begin
          if (host_wr) begin
            ready_handshake_out <= 1'b0;
          end else if (host_ready_set) begin
            ready_handshake_out <= 1'b1;
          end
        end else begin
          ready_handshake_out <= gport[0];
        end
      end
    end
  end
endmodule // msc_top

// [verif/msc_top_monitor.sv]
/*
  Port checker for msc_top, bound to every instance.
  Assumes one instruction cycle per clk_sys edge and rst_n active low.
*/
`timescale 1ns/1ps
// ==========================================
// Checker
module msc_top_monitor import msc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host strobes
  input wire logic interrupt_read_strobe_pin,
  input wire logic chip_select_event_pin,
  // Sequencer and status
  input wire logic instr_done,
  input wire logic [10:0] pc,
  input wire logic int_ack,
  input wire logic [3:0] en,
  input wire logic serial_out,
  input wire logic lport_oe,
  input wire logic [7:0] lport_out,
  input wire logic [7:0] qlatch,
  input wire logic [7:0] timer,
  input wire logic halted,
  input wire logic init_active,
  input wire logic host_fifo_full
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_count_out: assert property (en[0] && $stable(en) |-> serial_out == en[3])
    else $error("serial out differs from enable bit");
  a_shift_gated: assert property (!en[0] && !en[3] && $stable(en) |-> !serial_out)
    else $error("serial out not held low");
  a_ack_enable: assert property ($rose(int_ack) |-> $past(en[1]) || $past(en[1], 2))
    else $error("acknowledge without enable");
  a_ack_done: assert property ($rose(int_ack) |-> $past(instr_done) || $past(instr_done, 2))
    else $error("acknowledge without finished instruction");
  a_ack_vector: assert property ($rose(int_ack) |-> !en[MSC_EN_INT]
    && (pc == MSC_INT_VECTOR || $past(pc) == MSC_INT_VECTOR))
    else $error("acknowledge did not vector");
  a_read_drive: assert property (lport_oe && !en[2] && !$past(en[2])
    |-> $past(!chip_select_event_pin && !interrupt_read_strobe_pin, 2)
    || $past(!chip_select_event_pin && !interrupt_read_strobe_pin, 3)
    || $past(!chip_select_event_pin && !interrupt_read_strobe_pin, 4))
    else $error("port driven without selected read");
  a_read_data: assert property (lport_oe && $past(lport_oe) |-> lport_out == $past(qlatch))
    else $error("port data not latch contents");
  a_init_clear: assert property (init_active && $past(init_active)
    |-> pc == MSC_PC_RESET && en == MSC_EN_RESET && timer == 8'h00)
    else $error("registers not cleared during init");
  a_halt_freeze: assert property (halted && $past(halted)
    |-> $stable(pc) && $stable(timer) && $stable(en))
    else $error("state moved while halted");
  c_ack: cover property (int_ack);
  c_full: cover property (host_fifo_full);
  c_halt: cover property (halted);
  c_read: cover property (lport_oe && !en[2]);
endmodule // msc_top_monitor

bind msc_top msc_top_monitor msc_top_monitor_i (.*);

// [verif/msc_host_model.sv]
/*
  Host model on the 8-bit port; write strobe held four cycles, read strobe eight, for the device sync.
*/
`timescale 1ns/1ps
// ==========================================
// Host model
module msc_host_model (
  // Clock
  input wire logic clk_sys,
  // Strobes, active low
  output logic chip_select_event_pin,
  output logic interrupt_read_strobe_pin,
  output logic write_strobe_pin,
  // Port wire
  input wire logic [7:0] lport_out,
  input wire logic lport_oe,
  output logic [7:0] lport_in,
  // Read results
  output logic rd_done,
  output logic [7:0] rd_data,
  output logic saw_oe
);
  logic drv = 1'b0; // Host drives the port
  logic [7:0] dat = 8'h00; // Host data
  logic [7:0] last = 8'h00; // Last driven wire level
  // Released wire shows the inverse of its last level
  assign lport_in = lport_oe ? lport_out : drv ? dat : ~last;
  always @(posedge clk_sys) if (lport_oe || drv) last <= lport_in;
  initial begin
    {chip_select_event_pin, interrupt_read_strobe_pin, write_strobe_pin} = 3'h7;
    {rd_done, saw_oe, rd_data} = 10'h000;
  end
  // Write pulse with select low and data held throughout
  task wr_byte(input logic [7:0] d);
    @(posedge clk_sys) #1 {chip_select_event_pin, drv, dat} = {1'b0, 1'b1, d};
    write_strobe_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 write_strobe_pin = 1'b1;
    @(posedge clk_sys) #1 {chip_select_event_pin, drv} = 2'b10;
  endtask
  // Read pulse, selected or not; data taken after eight cycles whether or not the device drives
  task rd_byte(input logic sel);
    @(posedge clk_sys) #1 {chip_select_event_pin, interrupt_read_strobe_pin} = {~sel, 1'b0};
    saw_oe = 1'b0;
    repeat (8) @(posedge clk_sys) if (lport_oe === 1'b1) saw_oe = 1'b1;
    rd_data = lport_in;
    #1 {chip_select_event_pin, interrupt_read_strobe_pin, rd_done} = {2'b11, saw_oe};
    @(posedge clk_sys) #1 rd_done = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // msc_host_model

// [verif/msc_top_tb.sv]
/*
  Self-checking bench for msc_top with a host model on the port.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
`define WT(c, n) begin for (int k = 0; k < 60 && !(c); k++) cyc(1); \
  if (!(c)) begin bad_count++; $display("BAD wait %s", n); close_out(); end end
// ==========================================
// Bench top
module msc_top_tb;
  import msc_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, opt_host_bus = 1'b1, opt_timer_event = 1'b0;
  logic [1:0] opt_cko_mode = MSC_CKO_CRYSTAL;
  logic opt_dual_ext = 1'b0, reset_pin_n = 1'b1, in0_pin = 1'b1, serial_in_pin = 1'b0;
  logic chip_select_event_pin, interrupt_read_strobe_pin, write_strobe_pin;
  logic osc_out_halt_pin_in, osc_out_halt_pin_out, osc_out_halt_pin_oe, int_pin = 1'b1;
  logic [7:0] lport_in, lport_out, rd_data, qlatch, timer, load_timer_data = 8'h00;
  logic [7:0] core_wr_data = 8'h00, exp_v, b [4];
  logic lport_oe, serial_out, sync_clock_out, ready_handshake_out, rd_done, saw_oe;
  logic instr_done = 0, instr_is_transfer = 0, instr_is_lbi = 0, instr_jump = 0;
  logic instr_call = 0, return_instr = 0, halt_instr = 0, load_timer_instr = 0;
  logic exchange_acc_serial_instr = 0, read_input_latches_instr = 0, timer_ovf_clear = 0;
  logic skip_pending = 0, host_ready_set = 0, host_data_take = 0, alt_clock_sel = 0;
  logic [10:0] jump_addr = 11'h000, pc;
  logic [2:0] core_wr_sel = MSC_SEL_NONE;
  logic int_ack, skip_restore, carry, timer_ovf, halted, init_active, host_fifo_full;
  logic [3:0] acc, dout, gport, en, serial_shift_counter;
  logic [6:0] ram_addr;
  logic [7:0] exp_q [$];
  int bad_count = 0, total_checks = 0, ack_n = 0, sk_n = 0, seed_v;
  // Pin wire level from its driver
  assign osc_out_halt_pin_in = osc_out_halt_pin_oe ? osc_out_halt_pin_out : 1'b0;
  always #20 clk_sys = ~clk_sys;
  msc_top msc_top_i (.*);
  msc_host_model msc_host_model_i (.*);
  // Pulse counters and read comparison against queued expectations
  always @(posedge clk_sys) begin
    if (int_ack === 1'b1) ack_n++;
    if (skip_restore === 1'b1) sk_n++;
    if (rd_done === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK("host read", exp_v, rd_data)
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task set_en(input logic [3:0] v);
    {core_wr_sel, core_wr_data} = {MSC_SEL_EN, 4'h0, v};
    cyc(1);
    core_wr_sel = MSC_SEL_NONE;
    cyc(3);
  endtask
  task done_pulse(input logic xfer);
    {instr_done, instr_is_transfer} = {1'b1, xfer};
    cyc(1);
    {instr_done, instr_is_transfer} = 2'b00;
    cyc(4);
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    seed_v = $urandom(56100);
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    `WT(init_active === 1'b0, "init end")
    `CHK("pc", MSC_PC_RESET, pc)
    `CHK("acc", 4'h0, acc)
    `CHK("timer", 8'h00, timer)
    reset_pin_n = 1'b0;
    cyc(2);
    reset_pin_n = 1'b1;
    cyc(8);
    `CHK("short reset", 1'b0, init_active)
    $display("test reset done");
    set_en(4'h9);
    `CHK("so count", 1'b1, serial_out)
    `CHK("sk count", MSC_SKL_RESET, sync_clock_out)
    set_en(4'h1);
    `CHK("so count", 1'b0, serial_out)
    serial_in_pin = 1'b1;
    set_en(4'h0);
    cyc(6);
    `CHK("shift ones", 4'hf, serial_shift_counter)
    `CHK("so gated", 1'b0, serial_out)
    serial_in_pin = 1'b0;
    set_en(4'h8);
    cyc(6);
    `CHK("shift zeros", 4'h0, serial_shift_counter)
    $display("test serial done");
    host_ready_set = 1'b1;
    cyc(1);
    host_ready_set = 1'b0;
    cyc(2);
    `CHK("ready set", 1'b1, ready_handshake_out)
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      msc_host_model_i.wr_byte(b[i]);
    end
    cyc(4);
    `CHK("ready clear", 1'b0, ready_handshake_out)
    `CHK("fifo full", 1'b1, host_fifo_full)
    msc_host_model_i.wr_byte(~b[3]);
    for (int i = 0; i < 5; i++) begin
      host_data_take = 1'b1;
      cyc(1);
      host_data_take = 1'b0;
      cyc(2);
      `CHK("latch", b[i > 3 ? 3 : i], qlatch)
    end
    exp_q.push_back(b[3]);
    msc_host_model_i.rd_byte(1'b1);
    msc_host_model_i.rd_byte(1'b0);
    `CHK("unselected read", 1'b0, saw_oe)
    $display("test host bus done");
    int_pin = 1'b0;
    cyc(6);
    done_pulse(1'b0);
    `CHK("ack off", 0, ack_n)
    set_en(4'h2);
    done_pulse(1'b1);
    `CHK("ack deferred", 0, ack_n)
    skip_pending = 1'b1;
    done_pulse(1'b0);
    skip_pending = 1'b0;
    `WT(ack_n == 1, "ack")
    `CHK("vector", MSC_INT_VECTOR, pc)
    `CHK("int enable", 1'b0, en[MSC_EN_INT])
    return_instr = 1'b1;
    done_pulse(1'b0);
    return_instr = 1'b0;
    `CHK("skip restore", 1, sk_n)
    $display("test interrupt done");
    load_timer_data = 8'($urandom);
    load_timer_instr = 1'b1;
    cyc(1);
    load_timer_instr = 1'b0;
    cyc(32);
    exp_v = timer - load_timer_data;
    `CHK("time base", 1'b1, exp_v inside {8'h07, 8'h08})
    in0_pin = 1'b0;
    cyc(4);
    read_input_latches_instr = 1'b1;
    cyc(1);
    read_input_latches_instr = 1'b0;
    cyc(2);
    `CHK("input latch", 1'b1, acc[0])
    $display("test timer done");
    halt_instr = 1'b1;
    cyc(1);
    halt_instr = 1'b0;
    `WT(osc_out_halt_pin_out === 1'b1, "halt")
    `CHK("crystal stop", 1'b1, halted)
    reset_pin_n = 1'b0;
    `WT(init_active === 1'b1, "restart")
    reset_pin_n = 1'b1;
    `WT(init_active === 1'b0, "restart end")
    `CHK("halt left", 1'b0, halted)
    $display("test halt done");
    close_out();
  end
endmodule // msc_top_tb
